// File: rtl/caf_pkg.sv
// Package: encodings, field positions and types for the compact ALU decoder
package caf_pkg;
   // ========================================
   // Widths
   localparam int CAF_W        = 32;
   localparam int CAF_IW       = 16;
   localparam int CAF_RW       = 3;
   localparam int CAF_NREG     = 8;
   // ========================================
   // Format selectors (top bits of the halfword)
   localparam logic [2:0] CAF_TOP_SHIFT  = 3'h0;
   localparam logic [2:0] CAF_TOP_IMM8   = 3'h1;
   localparam logic [4:0] CAF_TOP_ADDSUB = 5'h03;
   // ========================================
   // Field positions
   localparam int CAF_OP_HI    = 12;
   localparam int CAF_OP_LO    = 11;
   localparam int CAF_SH_HI    = 10;
   localparam int CAF_SH_LO    = 6;
   localparam int CAF_AS_IMM   = 10;
   localparam int CAF_AS_SUB   = 9;
   localparam int CAF_RN_LO    = 6;
   localparam int CAF_RS_LO    = 3;
   localparam int CAF_RD_LO    = 0;
   localparam int CAF_I8_RD_LO = 8;
   // ========================================
   // Opcodes
   localparam logic [1:0] CAF_OP_LSL = 2'h0;
   localparam logic [1:0] CAF_OP_LSR = 2'h1;
   localparam logic [1:0] CAF_OP_ASR = 2'h2;
   localparam logic [1:0] CAF_OP_MOV = 2'h0;
   localparam logic [1:0] CAF_OP_CMP = 2'h1;
   localparam logic [1:0] CAF_OP_ADD = 2'h2;
   localparam logic [1:0] CAF_OP_SUB = 2'h3;
   // ========================================
   // Reset values and timing
   localparam logic [31:0] CAF_REG_RST   = 32'h0000_0000;
   localparam logic [3:0]  CAF_FLAGS_RST = 4'h0;
   localparam int CAF_EXEC_CYC = 1;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } caf_flags_t;

   typedef struct packed {
      logic [CAF_RW-1:0] addr;
      logic [CAF_W-1:0]  data;
      logic              we;
   } caf_wb_t;
endpackage

// File: rtl/caf_shifter.sv
// Immediate shifter for the shift-by-immediate format
`timescale 1ns/1ps
module caf_shifter
   import caf_pkg::*;
(
   input  wire logic [1:0]       op,
   input  wire logic [4:0]       shift_amount_imm,
   input  wire logic [CAF_W-1:0] value,
   input  wire logic             carry_in,
   output logic      [CAF_W-1:0] result,
   output logic                  carry_out
);
   // ========================================
   // Shift
   // Zero amount for right shifts means 32, as in the full-width form
   wire        zero_amt = (shift_amount_imm == 5'h0_0);
   wire [32:0] lsl_ext  = {1'b0, value} << shift_amount_imm;
   wire [32:0] lsr_ext  = {value, 1'b0} >> shift_amount_imm;
   wire [32:0] asr_ext  = $signed({value, 1'b0}) >>> shift_amount_imm;
   wire        sign     = value[CAF_W-1];

   always_comb begin
      result    = value;
      carry_out = carry_in;
      case (op)
         CAF_OP_LSL: begin
            result    = lsl_ext[CAF_W-1:0];
            carry_out = zero_amt ? carry_in : lsl_ext[CAF_W];
         end
         CAF_OP_LSR: begin
            result    = zero_amt ? '0 : lsr_ext[CAF_W:1];
            carry_out = zero_amt ? sign : lsr_ext[0];
         end
         CAF_OP_ASR: begin
            result    = zero_amt ? {CAF_W{sign}} : asr_ext[CAF_W:1];
            carry_out = zero_amt ? sign : asr_ext[0];
         end
         default: begin
            result    = value;
            carry_out = carry_in;
         end
      endcase
   end
endmodule

// File: rtl/caf_adder.sv
// Adder and subtractor with carry and overflow outputs
`timescale 1ns/1ps
module caf_adder
   import caf_pkg::*;
(
   input  wire logic [CAF_W-1:0] a,
   input  wire logic [CAF_W-1:0] b,
   input  wire logic             sub,
   output logic      [CAF_W-1:0] sum,
   output logic                  carry,
   output logic                  overflow
);
   // ========================================
   // Add with inverted operand for subtract; carry means no borrow
   wire [CAF_W-1:0] b_eff = sub ? ~b : b;
   wire [CAF_W:0]   full  = {1'b0, a} + {1'b0, b_eff} + {{CAF_W{1'b0}}, sub};

   assign sum      = full[CAF_W-1:0];
   assign carry    = full[CAF_W];
   assign overflow = (a[CAF_W-1] == b_eff[CAF_W-1]) &&
                     (sum[CAF_W-1] != a[CAF_W-1]);
endmodule

// File: rtl/caf_decoder.sv
// Decode and execute for shift, add/subtract and 8-bit immediate formats
// Function
// - Opcode 00 shifts source left by immediate amount into destination
// - Opcode 01 shifts source right logically by immediate amount
// - Opcode 10 shifts source right arithmetically by immediate amount
// - Shift format uses low bank registers only
// - All three formats update the condition flags from result
// - Control bits 00 add second operand register to source
// - Control bits 01 subtract second operand register from source
// - Control bits 10 add 3-bit immediate to source
// - Control bits 11 subtract 3-bit immediate from source
// - Add/subtract operands are low registers or 3-bit immediate
// - Immediate format pairs one low register with an 8-bit constant
// - Opcode 00 loads 8-bit immediate into destination
// - Opcode 01 compares destination with immediate, flags only
// - Opcode 10 adds immediate to destination, writes back
// - Opcode 11 subtracts immediate from destination, writes back
// - Each instruction takes the cycles of its full-width equivalent
// - Adds of formats 5, 12, 13 leave flags unchanged
// - Register move of format 5 leaves flags unchanged
`timescale 1ns/1ps
module caf_decoder
   import caf_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire logic              instr_valid,
   input  wire logic [CAF_IW-1:0] instr,
   output logic                   instr_ready,
   output logic                   instr_accepted,
   output logic                   instr_unsupported,
   output caf_flags_t             program_status_word,
   output caf_wb_t                wb,
   input  wire logic [CAF_RW-1:0] dbg_addr,
   output logic      [CAF_W-1:0]  dbg_data
);
   // ========================================
   // Low register bank
   logic [CAF_W-1:0] low_bank_register [CAF_NREG];
   caf_flags_t       psw_reg;
   caf_flags_t       psw_next;
   caf_wb_t          wb_reg;
   logic             unsup_reg;
   logic             acc_reg;

   // ========================================
   // Format decode
   wire [1:0] op       = instr[CAF_OP_HI:CAF_OP_LO];
   wire is_addsub      = (instr[15:11] == CAF_TOP_ADDSUB);
   wire is_shift       = (instr[15:13] == CAF_TOP_SHIFT) && !is_addsub;
   wire is_imm8        = (instr[15:13] == CAF_TOP_IMM8);
   wire supported      = is_shift || is_addsub || is_imm8;
   wire fire           = clk_en && instr_valid;

   // Register selects are 3 bits wide, so no high bank can be reached
   wire [CAF_RW-1:0] rd_sel = is_imm8 ?
        instr[CAF_I8_RD_LO +: CAF_RW] : instr[CAF_RD_LO +: CAF_RW];
   wire [CAF_RW-1:0] source_reg_sel = instr[CAF_RS_LO +: CAF_RW];
   wire [CAF_RW-1:0] second_operand_reg_sel =
        instr[CAF_RN_LO +: CAF_RW];

   wire [CAF_W-1:0] source_reg         = low_bank_register[source_reg_sel];
   wire [CAF_W-1:0] second_operand_reg =
        low_bank_register[second_operand_reg_sel];
   wire [CAF_W-1:0] dest_val           = low_bank_register[rd_sel];

   wire [4:0] shift_amount_imm = instr[CAF_SH_HI:CAF_SH_LO];
   wire [CAF_W-1:0] small_imm  =
        {29'h0000_0000, instr[CAF_RN_LO +: 3]};
   wire [CAF_W-1:0] byte_imm   = {24'h00_0000, instr[7:0]};

   // ========================================
   // Datapath
   wire [CAF_W-1:0] sh_res;
   wire             sh_c;
   caf_shifter u_shift (
      .op               (op),
      .shift_amount_imm (shift_amount_imm),
      .value            (source_reg),
      .carry_in         (psw_reg.c),
      .result           (sh_res),
      .carry_out        (sh_c)
   );

   // Add/subtract: imm bit picks small_imm, sub bit picks subtract
   wire as_imm = instr[CAF_AS_IMM];
   wire as_sub = instr[CAF_AS_SUB];
   wire [CAF_W-1:0] add_a = is_imm8 ? dest_val : source_reg;
   wire [CAF_W-1:0] add_b = is_imm8 ? byte_imm :
                            (as_imm ? small_imm
                                    : second_operand_reg);
   wire add_sub = is_imm8 ? (op == CAF_OP_CMP || op == CAF_OP_SUB)
                          : as_sub;
   wire [CAF_W-1:0] add_res;
   wire             add_c;
   wire             add_v;
   caf_adder u_add (
      .a        (add_a),
      .b        (add_b),
      .sub      (add_sub),
      .sum      (add_res),
      .carry    (add_c),
      .overflow (add_v)
   );

   // ========================================
   // Result select
   wire imm_mov  = is_imm8 && (op == CAF_OP_MOV);
   wire imm_cmp  = is_imm8 && (op == CAF_OP_CMP);
   wire use_add  = is_addsub || (is_imm8 && !imm_mov);
   wire [CAF_W-1:0] result = is_shift ? sh_res :
                             imm_mov  ? byte_imm : add_res;
   wire do_write = supported && !imm_cmp;

   // Moves and shifts keep V; shifts drive C; moves keep C
   always_comb begin
      psw_next   = psw_reg;
      psw_next.n = result[CAF_W-1];
      psw_next.z = (result == CAF_REG_RST);
      if (use_add) begin
         psw_next.c = add_c;
         psw_next.v = add_v;
      end else if (is_shift) begin
         psw_next.c = sh_c;
      end
   end

   // ========================================
   // Handshake: one instruction per cycle, same as the full-width
   // single-cycle data processing forms
   assign instr_ready = clk_en;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         psw_reg   <= CAF_FLAGS_RST;
         wb_reg    <= '0;
         unsup_reg <= 1'b0;
         acc_reg   <= 1'b0;
      end else if (clk_en) begin
         acc_reg   <= fire && supported;
         unsup_reg <= fire && !supported;
         wb_reg.we <= fire && do_write;
         if (fire && supported) begin
            // Flag-preserving adds and moves sit in other formats
            psw_reg     <= psw_next;
            wb_reg.addr <= rd_sel;
            wb_reg.data <= result;
         end
      end
   end

   // Bank write, one generate entry per register
   for (genvar i = 0; i < CAF_NREG; i++) begin : g_bank
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            low_bank_register[i] <= CAF_REG_RST;
         end else if (clk_en && fire && do_write &&
                      rd_sel == CAF_RW'(i)) begin
            low_bank_register[i] <= result;
         end
      end
   end

   assign instr_accepted      = acc_reg;
   assign instr_unsupported   = unsup_reg;
   assign program_status_word = psw_reg;
   assign wb                  = wb_reg;
   assign dbg_data            = low_bank_register[dbg_addr];
endmodule

// File: dv/caf_decoder_checker.sv
// Concurrent checks on the decoder ports
`timescale 1ns/1ps
module caf_decoder_checker
   import caf_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              rst_n,
   input wire logic              clk_en,
   input wire logic              instr_valid,
   input wire logic [CAF_IW-1:0] instr,
   input wire logic              instr_ready,
   input wire logic              instr_accepted,
   input wire logic              instr_unsupported,
   input wire caf_flags_t        program_status_word,
   input wire caf_wb_t           wb,
   input wire logic [CAF_RW-1:0] dbg_addr,
   input wire logic [CAF_W-1:0]  dbg_data
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire tk = clk_en && instr_valid;
   wire sh = instr[15:13] == 3'h0 && instr[12:11] != 2'h3;
   wire as = instr[15:11] == CAF_TOP_ADDSUB;
   wire i8 = instr[15:13] == CAF_TOP_IMM8;
   sequence s_mov; tk && i8 && instr[12:11] == CAF_OP_MOV; endsequence
   sequence s_cmp; tk && i8 && instr[12:11] == CAF_OP_CMP; endsequence
   AST_READY: assert property (instr_ready == clk_en)
      else $error("ready differs from enable");
   AST_ONE_CYCLE: assert property (tk && (sh || as || i8) |=>
      instr_accepted && !instr_unsupported) else $error("not taken");
   AST_REFUSE: assert property (tk && !(sh || as || i8) |=>
      instr_unsupported && !wb.we &&
      program_status_word == $past(program_status_word))
      else $error("refused word changed state");
   AST_IDLE: assert property (clk_en && !instr_valid |=>
      !instr_accepted && !wb.we) else $error("idle cycle acted");
   AST_MOV: assert property (s_mov |=> wb.we &&
      wb.addr == $past(instr[10:8]) && wb.data == 32'($past(instr[7:0]))
      && !program_status_word.n
      && program_status_word.z == ($past(instr[7:0]) == 8'h00))
      else $error("move result wrong");
   AST_CMP: assert property (s_cmp |=> !wb.we)
      else $error("compare wrote a register");
   AST_KEEP_CV: assert property (s_mov |=>
      program_status_word.c == $past(program_status_word.c) &&
      program_status_word.v == $past(program_status_word.v))
      else $error("move altered carry or overflow");
   AST_DEST: assert property (tk && (sh || as) |=>
      wb.we && wb.addr == $past(instr[2:0])) else $error("bad dest");
   AST_FREEZE: assert property (!clk_en |=>
      $stable(program_status_word) && $stable(wb))
      else $error("state moved while disabled");
   AST_DBG: assert property (wb.we && dbg_addr == wb.addr |->
      dbg_data == wb.data) else $error("bank differs from write");
endmodule

bind caf_decoder caf_decoder_checker i_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
   .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
   .instr_accepted(instr_accepted), .instr_unsupported(instr_unsupported),
   .program_status_word(program_status_word), .wb(wb),
   .dbg_addr(dbg_addr), .dbg_data(dbg_data));

// File: dv/caf_fetch_model.sv
// Fetch stage model offering halfwords to the decoder
`timescale 1ns/1ps
module caf_fetch_model
   import caf_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              offer,
   input  wire logic              stall,
   input  wire logic [CAF_IW-1:0] word,
   output logic                   instr_valid,
   output logic                   clk_en,
   output logic      [CAF_IW-1:0] instr
);
   logic [CAF_IW-1:0] last_reg = 16'h0000;
   // Idle bus shows the inverse of the last word so no stale value passes
   assign instr = offer ? word : ~last_reg;
   assign instr_valid = offer;
   assign clk_en = !stall;
   always @(posedge sys_clk) last_reg <= instr;
endmodule

// File: dv/caf_decoder_bench.sv
// Self-checking bench for the compact ALU format decoder
`timescale 1ns/1ps
module caf_decoder_bench;
   import caf_pkg::*;
   typedef struct packed {
      logic acc, unsup; caf_wb_t wb; caf_flags_t f;
   } caf_note_t;
   logic sys_clk = 0, rst_n = 0, stall = 1, offer = 0, took = 0;
   logic [15:0] word = 16'h0000;
   logic [2:0] dbg_addr = 3'h0;
   logic clk_en, instr_valid, instr_ready, acc, uns;
   logic [CAF_IW-1:0] instr;
   caf_flags_t psw, fm;
   caf_wb_t wb;
   logic [CAF_W-1:0] dbg_data, bank [CAF_NREG];
   caf_note_t notes [$];
   int n_errors = 0, samples_checked = 0;
   always #2.5 sys_clk = ~sys_clk;
   caf_fetch_model i_fetch (.sys_clk(sys_clk), .offer(offer),
      .stall(stall), .word(word), .instr_valid(instr_valid),
      .clk_en(clk_en), .instr(instr));
   caf_decoder i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
      .instr_accepted(acc), .instr_unsupported(uns),
      .program_status_word(psw), .wb(wb), .dbg_addr(dbg_addr),
      .dbg_data(dbg_data));
   task automatic check(input logic [41:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("Checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Reference model: works the result out from the rules alone
   task automatic exec(input logic [15:0] i);
      caf_note_t e;
      logic [31:0] a, b, r;
      logic [32:0] s;
      logic [5:0] m;
      logic sub, wr, ar;
      e = '0; e.f = fm; wr = 1; ar = 0; sub = 0; r = '0;
      a = bank[i[5:3]];
      m = (i[10:6] == 5'h00) ? 6'h20 : 6'(i[10:6]);
      b = i[10] ? 32'(i[8:6]) : bank[i[8:6]];
      if (i[15:11] == CAF_TOP_ADDSUB) begin
         ar = 1; sub = i[9];
      end else if (i[15:13] == CAF_TOP_IMM8) begin
         a = bank[i[10:8]]; b = 32'(i[7:0]); r = b;
         ar = i[12:11] != CAF_OP_MOV; sub = i[11];
         wr = i[12:11] != CAF_OP_CMP;
      end else if (i[15:13] == CAF_TOP_SHIFT) begin
         case (i[12:11]) // A zero amount on right shifts means 32
            CAF_OP_LSL: {e.f.c, r} = {fm.c, a} << i[10:6];
            CAF_OP_LSR: {r, e.f.c} = {a, 1'b0} >> m;
            default: {r, e.f.c} = $signed({a, 1'b0}) >>> m;
         endcase
      end else begin
         e.unsup = 1; wr = 0;
      end
      if (ar) begin
         s = sub ? {1'b0, a} + {1'b0, ~b} + 33'h1 : {1'b0, a} + {1'b0, b};
         r = s[31:0]; e.f.c = s[32];
         e.f.v = (a[31] == (b[31] ^ sub)) && (r[31] != a[31]);
      end
      e.acc = !e.unsup;
      if (e.acc) begin
         e.f.n = r[31]; e.f.z = r == 0; fm = e.f;
         if (wr) begin
            e.wb = {(i[15:13] == CAF_TOP_IMM8) ? i[10:8] : i[2:0], r, 1'b1};
            bank[e.wb.addr] = r;
         end
      end
      notes.push_back(e);
   endtask
   always @(negedge sys_clk) begin
      caf_note_t e, got;
      #1;
      check(42'(dbg_data), 42'(bank[dbg_addr]));
      if (took) begin
         e = notes.pop_front();
         got = {acc, uns, wb, psw};
         if (!e.wb.we) begin // Stale address and data; the strobe is still checked
            got.wb.addr = '0;
            got.wb.data = '0;
         end
         check(got, e);
      end
   end
   initial begin
      #10000;
      n_errors++;
      close_out;
   end
   initial begin
      void'($urandom(32'h469389d6));
      foreach (bank[k]) bank[k] = '0;
      fm = '0;
      repeat (4) @(posedge sys_clk);
      for (int t = 0; t < 900; t++) begin
         @(negedge sys_clk);
         rst_n = t != 450;
         if (!rst_n) begin // Mid-run reset clears bank and flags
            foreach (bank[k]) bank[k] = '0;
            fm = '0; took = 0; notes.delete();
         end
         stall = ($urandom % 8) == 0;
         dbg_addr = 3'($urandom);
         if (!(offer && !took)) begin // A refused word is held
            offer = ($urandom % 6) != 0;
            case ($urandom % 4)
               0: word = {3'h0, 2'($urandom % 3), 11'($urandom)};
               1: word = {CAF_TOP_ADDSUB, 11'($urandom)};
               2: word = {CAF_TOP_IMM8, 13'($urandom)};
               default: word = {3'($urandom % 6 + 2), 13'($urandom)};
            endcase
         end
         @(posedge sys_clk);
         took = rst_n && clk_en && instr_valid;
         if (took) exec(instr);
      end
      close_out;
   end
endmodule
